// ===== verilog/scas_top.sv
// SIM card port sequencer: card clock, activation and deactivation for
// two independent card ports.
// Assumes control inputs come from logic on clk_sys; card pins and the
// slow reference clock are asynchronous to it.
`timescale 1ns/100ps
`default_nettype none

`include "scas_params.svh"

module scas_top
   import scas_pkg::*;
#(
   parameter int unsigned RST_LOW_CYC = `SCAS_RST_LOW_CYC,
   parameter int unsigned ATR_MAX_CYC = `SCAS_ATR_MAX_CYC
)(
   // System clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // Slow reference clock for deactivation
   input  wire logic        slow_reference_clock,
   // Per-port commands, one bit per port
   input  wire logic [1:0]  act_start,
   input  wire logic [1:0]  act_low_reset_card,
   input  wire logic [1:0]  power_down,
   // Per-port configuration
   input  wire logic [1:0]  ratio_16,
   input  wire logic [1:0]  five_pin_mode,
   input  wire logic [25:0] clk_half_period,
   // Transmit bit from the character logic
   input  wire logic [1:0]  tx_bit,
   // Per-port status
   output logic      [1:0]  port_active,
   output logic      [1:0]  port_fail,
   output logic      [1:0]  port_busy,
   output logic      [1:0]  etu_tick,
   output logic      [1:0]  rx_bit,
   // Card pins, six-pin form
   input  wire logic [1:0]  card_presence_detect,
   input  wire logic [1:0]  card_rx_in,
   output logic      [1:0]  card_clock_out,
   output logic      [1:0]  card_rst_out,
   output logic      [1:0]  card_tx_out,
   output logic      [1:0]  card_ven_out,
   // Card data pin, five-pin form
   input  wire logic [1:0]  bidirectional_card_data_in,
   output logic      [1:0]  bidirectional_card_data_out,
   output logic      [1:0]  bidirectional_card_data_oe
);

   localparam logic [12:0] HALF_MIN  = 13'(`SCAS_HALF_MIN);
   localparam logic [12:0] HALF_MAX  = 13'(`SCAS_HALF_MAX);
   localparam logic [8:0]  RATIO_STD = 9'(`SCAS_RATIO_STD);
   localparam logic [8:0]  RATIO_ALT = 9'(`SCAS_RATIO_ALT);
   localparam logic [15:0] SETTLE    = 16'(`SCAS_RX_SETTLE_CYC);
   localparam logic [15:0] ATR_MIN   = 16'(`SCAS_ATR_MIN_CYC);
   localparam logic [15:0] ATR_MAX   = 16'(ATR_MAX_CYC);
   localparam logic [15:0] RST_LOW   = 16'(RST_LOW_CYC);

   ////////////////////////////////////////////////////////////////////////
   // One sequencer per card port
   ////////////////////////////////////////////////////////////////////////
   genvar p;
   generate
      for (p = 0; p < 2; p++) begin : g_port

         scas_state_t state_r;
         scas_state_t state_nxt;
         logic [12:0] half_lim;
         logic [12:0] half_cnt_r;
         logic        cclk_r;
         logic        cclk_run;
         logic        cclk_rise;
         logic [8:0]  etu_cnt_r;
         logic [8:0]  etu_lim;
         logic [15:0] cyc_r;
         logic        present_s;
         logic        rx_pin_s;
         logic        rx_bidir_s;
         logic        rx_sel;
         logic        rx_prev_r;
         logic        rx_fall;
         logic        deact_req_r;
         logic [2:0]  step_s;
         logic        slow_clk_stop;
         logic        slow_tx_low;
         logic        slow_ven_low;
         logic        remove_evt;
         logic        early_fail;
         logic        late_fail;
         logic        start_deact;

         ///////////////////////////////////////////////////////////////////
         // Pin synchronisers
         ///////////////////////////////////////////////////////////////////

         // Presence, receive line and two-way data line
         scas_sync2 #(.WIDTH(3)) u_pin_sync (
            .clk  (clk_sys),
            .rst  (rst),
            .din  ({card_presence_detect[p], card_rx_in[p],
                    bidirectional_card_data_in[p]}),
            .dout ({present_s, rx_pin_s, rx_bidir_s})
         );

         // Deactivation steps coming back from the slow domain
         scas_sync2 #(.WIDTH(3)) u_step_sync (
            .clk  (clk_sys),
            .rst  (rst),
            .din  ({slow_clk_stop, slow_tx_low, slow_ven_low}),
            .dout (step_s)
         );

         // Deactivation stepper on the slow clock
         scas_deact_seq u_deact (
            .slow_reference_clock (slow_reference_clock),
            .rst                  (rst),
            .deact_req            (deact_req_r),
            .clk_stop             (slow_clk_stop),
            .tx_low               (slow_tx_low),
            .ven_low              (slow_ven_low)
         );

         ///////////////////////////////////////////////////////////////////
         // Card clock generator
         ///////////////////////////////////////////////////////////////////

         // Clamp the programmed half period to the legal range
         always_comb begin
            half_lim = clk_half_period[13*p +: 13];
            if (half_lim < HALF_MIN) begin
               half_lim = HALF_MIN;
            end else if (half_lim > HALF_MAX) begin
               half_lim = HALF_MAX;
            end
         end

         // Clock runs from activation until the clock-stop step
         assign cclk_run = !(state_r == SCAS_IDLE || state_r == SCAS_CLEAR ||
                             (state_r == SCAS_DEACT && step_s[2]));
         assign cclk_rise = cclk_run && !cclk_r && (half_cnt_r >= half_lim - 13'h1);

         // Equal high and low halves
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               half_cnt_r <= 13'h0;
               cclk_r     <= 1'b0;
            end else if (!cclk_run) begin
               half_cnt_r <= 13'h0;
               cclk_r     <= 1'b0;
            end else if (half_cnt_r >= half_lim - 13'h1) begin
               half_cnt_r <= 13'h0;
               cclk_r     <= ~cclk_r;
            end else begin
               half_cnt_r <= half_cnt_r + 13'h1;
            end
         end

         ///////////////////////////////////////////////////////////////////
         // Bit-time tick for the character logic
         ///////////////////////////////////////////////////////////////////

         assign etu_lim = ratio_16[p] ? RATIO_ALT : RATIO_STD;

         // One pulse per bit time, counted in card clocks
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               etu_cnt_r   <= 9'h0;
               etu_tick[p] <= 1'b0;
            end else if (!cclk_run) begin
               etu_cnt_r   <= 9'h0;
               etu_tick[p] <= 1'b0;
            end else if (cclk_rise && etu_cnt_r >= etu_lim - 9'h1) begin
               etu_cnt_r   <= 9'h0;
               etu_tick[p] <= 1'b1;
            end else begin
               etu_cnt_r   <= cclk_rise ? etu_cnt_r + 9'h1 : etu_cnt_r;
               etu_tick[p] <= 1'b0;
            end
         end

         ///////////////////////////////////////////////////////////////////
         // Receive line and answer detection
         ///////////////////////////////////////////////////////////////////

         assign rx_sel  = five_pin_mode[p] ? rx_bidir_s : rx_pin_s;
         assign rx_fall = rx_prev_r && !rx_sel && (cyc_r >= SETTLE);

         // Edge history and registered copy for the character logic
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               rx_prev_r <= 1'b0;
               rx_bit[p] <= 1'b1;
            end else begin
               rx_prev_r <= rx_sel;
               rx_bit[p] <= rx_sel;
            end
         end

         // Answer too early, or none in time
         assign early_fail = rx_fall && (cyc_r < ATR_MIN);
         assign late_fail  = !rx_fall && (cyc_r >= ATR_MAX);
         assign remove_evt = !present_s;
         assign start_deact = remove_evt || power_down[p];

         ///////////////////////////////////////////////////////////////////
         // Card clock cycle counter
         ///////////////////////////////////////////////////////////////////

         // Cleared at each time zero, saturates at the top
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               cyc_r <= 16'h0;
            end else if (state_nxt != state_r) begin
               cyc_r <= 16'h0;
            end else if (cclk_rise && cyc_r != 16'hFFFF) begin
               cyc_r <= cyc_r + 16'h1;
            end
         end

         ///////////////////////////////////////////////////////////////////
         // Sequencer
         ///////////////////////////////////////////////////////////////////

         // Next state
         always_comb begin
            state_nxt = state_r;
            case (state_r)
               SCAS_IDLE: begin
                  if (act_start[p] && present_s) begin
                     state_nxt = act_low_reset_card[p] ? SCAS_RST_LOW : SCAS_CLK_RUN;
                  end
               end
               SCAS_CLK_RUN: begin
                  if (start_deact || early_fail || late_fail) begin
                     state_nxt = SCAS_DEACT;
                  end else if (rx_fall) begin
                     state_nxt = SCAS_ACTIVE;
                  end
               end
               SCAS_RST_LOW: begin
                  if (start_deact || rx_fall) begin
                     state_nxt = SCAS_DEACT;
                  end else if (cyc_r >= RST_LOW) begin
                     state_nxt = SCAS_RST_HIGH;
                  end
               end
               SCAS_RST_HIGH: begin
                  if (start_deact || early_fail || late_fail) begin
                     state_nxt = SCAS_DEACT;
                  end else if (rx_fall) begin
                     state_nxt = SCAS_ACTIVE;
                  end
               end
               SCAS_ACTIVE: begin
                  if (start_deact) begin
                     state_nxt = SCAS_DEACT;
                  end
               end
               SCAS_DEACT: begin
                  if (step_s[0]) begin
                     state_nxt = SCAS_CLEAR;
                  end
               end
               SCAS_CLEAR: begin
                  if (step_s == 3'h0) begin
                     state_nxt = SCAS_IDLE;
                  end
               end
               default: begin
                  state_nxt = SCAS_IDLE;
               end
            endcase
         end

         // State register
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               state_r <= SCAS_IDLE;
            end else begin
               state_r <= state_nxt;
            end
         end

         // Deactivation request held until the last step is seen
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               deact_req_r <= 1'b0;
            end else begin
               deact_req_r <= (state_nxt == SCAS_DEACT);
            end
         end

         // Failure flag, kept until the next activation
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               port_fail[p] <= 1'b0;
            end else if ((state_r == SCAS_CLK_RUN || state_r == SCAS_RST_LOW ||
                          state_r == SCAS_RST_HIGH) && state_nxt == SCAS_DEACT &&
                         !start_deact) begin
               port_fail[p] <= 1'b1;
            end else if (state_r == SCAS_IDLE && state_nxt != SCAS_IDLE) begin
               port_fail[p] <= 1'b0;
            end
         end

         ///////////////////////////////////////////////////////////////////
         // Card pin drivers
         ///////////////////////////////////////////////////////////////////

         // Reset, data, supply and clock pins
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               card_clock_out[p] <= 1'b0;
               card_rst_out[p]   <= 1'b0;
               card_tx_out[p]    <= 1'b0;
               card_ven_out[p]   <= 1'b0;
            end else begin
               card_clock_out[p] <= cclk_r;
               card_rst_out[p]   <= (state_nxt == SCAS_RST_HIGH) ||
                                    (state_nxt == SCAS_ACTIVE && act_low_reset_card[p]);
               case (state_nxt)
                  SCAS_CLK_RUN, SCAS_RST_LOW, SCAS_RST_HIGH: begin
                     card_tx_out[p]  <= 1'b1;
                     card_ven_out[p] <= 1'b1;
                  end
                  SCAS_ACTIVE: begin
                     card_tx_out[p]  <= tx_bit[p];
                     card_ven_out[p] <= 1'b1;
                  end
                  SCAS_DEACT: begin
                     card_tx_out[p]  <= !step_s[1];
                     card_ven_out[p] <= !step_s[0];
                  end
                  default: begin
                     card_tx_out[p]  <= 1'b0;
                     card_ven_out[p] <= 1'b0;
                  end
               endcase
            end
         end

         // Five-pin form pulls the shared line low, never drives high
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               bidirectional_card_data_oe[p] <= 1'b0;
            end else begin
               bidirectional_card_data_oe[p] <= five_pin_mode[p] &&
                                                (state_nxt == SCAS_ACTIVE) && !tx_bit[p];
            end
         end
         assign bidirectional_card_data_out[p] = 1'b0;

         // Status levels
         assign port_active[p] = (state_r == SCAS_ACTIVE);
         assign port_busy[p]   = (state_r != SCAS_IDLE) && (state_r != SCAS_ACTIVE);

      end
   endgenerate

endmodule

`default_nettype wire

// ===== verilog/scas_params.svh
// Constants for the SIM card activation sequencer.
// Assumes a 100 MHz system clock and a free-running slow reference clock.
`ifndef SCAS_PARAMS_SVH
`define SCAS_PARAMS_SVH

// System clock rate and card clock range, in Hz
`define SCAS_SYS_HZ        100000000
`define SCAS_CARD_FMAX_HZ  5000000
`define SCAS_CARD_FMIN_HZ  10000

// Half-period limits of the card clock, in system cycles
`define SCAS_HALF_MIN      (`SCAS_SYS_HZ / (2 * `SCAS_CARD_FMAX_HZ))
`define SCAS_HALF_MAX      (`SCAS_SYS_HZ / (2 * `SCAS_CARD_FMIN_HZ))

// Card clocks per bit on the data lines
`define SCAS_RATIO_STD     372
`define SCAS_RATIO_ALT     16

// Activation windows, in card clock cycles
`define SCAS_RX_SETTLE_CYC 200
`define SCAS_ATR_MIN_CYC   400
`define SCAS_ATR_MAX_CYC   40000
`define SCAS_RST_LOW_CYC   40000

// Last deactivation step on the slow clock
`define SCAS_DEACT_LAST    2'h3

`endif

// ===== verilog/scas_pkg.sv
// Types shared by the SIM card activation sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package scas_pkg;

   // Per-port sequencer states, one-hot
   typedef enum logic [6:0] {
      SCAS_IDLE     = 7'h01,
      SCAS_CLK_RUN  = 7'h02,
      SCAS_RST_LOW  = 7'h04,
      SCAS_RST_HIGH = 7'h08,
      SCAS_ACTIVE   = 7'h10,
      SCAS_DEACT    = 7'h20,
      SCAS_CLEAR    = 7'h40
   } scas_state_t;

endpackage

`default_nettype wire

// ===== verilog/scas_sync2.sv
// Two-flop synchroniser, one stage pair per bit.
// Assumes each bit is a level that changes rarely against clk.
`timescale 1ns/100ps
`default_nettype none

module scas_sync2 #(
   parameter int unsigned WIDTH = 1
)(
   // Destination clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Asynchronous level in, synchronised level out
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta_r;

   // First flop read only by the second
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r <= '0;
         dout   <= '0;
      end else begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end

endmodule

`default_nettype wire

// ===== verilog/scas_deact_seq.sv
// Deactivation stepper on the slow reference clock.
// Assumes the request is a level from the system domain, held until
// the system side has seen the last step, then dropped.
`timescale 1ns/100ps
`default_nettype none

`include "scas_params.svh"

module scas_deact_seq
   import scas_pkg::*;
(
   // Slow clock and reset
   input  wire logic slow_reference_clock,
   input  wire logic rst,
   // Request level from the system domain
   input  wire logic deact_req,
   // Step levels, thermometer coded
   output logic      clk_stop,
   output logic      tx_low,
   output logic      ven_low
);

   logic       req_s;
   logic [1:0] step_r;

   // Bring the request into the slow domain
   scas_sync2 #(.WIDTH(1)) u_req_sync (
      .clk  (slow_reference_clock),
      .rst  (rst),
      .din  (deact_req),
      .dout (req_s)
   );

   // One step per slow period, cleared when the request drops
   always_ff @(posedge slow_reference_clock or posedge rst) begin
      if (rst) begin
         step_r <= 2'h0;
      end else if (!req_s) begin
         step_r <= 2'h0;
      end else if (step_r != `SCAS_DEACT_LAST) begin
         step_r <= step_r + 2'h1;
      end
   end

   // Clock, then data, then supply, in that order
   always_ff @(posedge slow_reference_clock or posedge rst) begin
      if (rst) begin
         clk_stop <= 1'b0;
         tx_low   <= 1'b0;
         ven_low  <= 1'b0;
      end else begin
         clk_stop <= req_s && (step_r >= 2'h1);
         tx_low   <= req_s && (step_r >= 2'h2);
         ven_low  <= req_s && (step_r == `SCAS_DEACT_LAST);
      end
   end

endmodule

`default_nettype wire

// ===== sim/scas_card_model.sv
// Card model for one port: counts card clock rises, answers at a set count.
// Assumes the receive line has a pull-up while the card is unpowered.
`timescale 1ns/100ps
`default_nettype none

module scas_card_model (
   // Card pins
   input  wire logic        cclk,
   input  wire logic        ven,
   input  wire logic        rst_pin,
   output logic             rx,
   // Answer count (0 = silent), answer only after reset release
   input  wire logic [31:0] ans_at,
   input  wire logic        wait_rst
);
   int n = 0;
   int base = 0;

   // Rise count; the base restarts at power-up and at each reset pin edge
   always @(posedge cclk) n = n + 1;
   always @(rst_pin or ven) base = n;

   // Line low until 200 rises, then high but for a start bit
   always_comb rx = !ven ? 1'b1 : (n - base < 200) ? 1'b0 :
      !(ans_at != 0 && (rst_pin || !wait_rst) && n - base >= ans_at && n - base < ans_at + 10);
endmodule

`default_nettype wire

// ===== sim/scas_top_chk.sv
// Checker on port 0 pins of the sequencer.
// Assumes the card clock is slow against clk_sys.
`timescale 1ns/100ps
`default_nettype none

module scas_top_chk #(
   parameter int unsigned RST_LOW_CYC = 40000,
   parameter int unsigned ATR_MAX_CYC = 40000
)(
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       rst,
   // Watched ports
   input wire logic [1:0] power_down,
   input wire logic [1:0] port_active,
   input wire logic [1:0] port_fail,
   input wire logic [1:0] port_busy,
   input wire logic [1:0] card_clock_out,
   input wire logic [1:0] card_rst_out,
   input wire logic [1:0] card_tx_out,
   input wire logic [1:0] card_ven_out
);
   int unsigned n_r;

   // Card clock rises since power-up or reset pin edge
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst)
         n_r <= 0;
      else if (!card_ven_out[0] || $changed(card_rst_out[0]))
         n_r <= 0;
      else if ($rose(card_clock_out[0]))
         n_r <= n_r + 1;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   chk_idle_pins_low: assert property (!port_busy[0] && !port_active[0] |->
      !(card_rst_out[0] | card_clock_out[0] | card_tx_out[0] | card_ven_out[0])) else $error("pins not low in idle");
   chk_ven_drops_last: assert property (!card_ven_out[0] |->
      !(card_rst_out[0] | card_clock_out[0] | card_tx_out[0])) else $error("pin high without supply");
   chk_tx_after_clk: assert property (port_busy[0] && $fell(card_tx_out[0]) |->
      !card_clock_out[0] && !card_rst_out[0]) else $error("data low before clock stop");
   chk_ven_spacing: assert property ($fell(card_ven_out[0]) |-> !$past(card_tx_out[0], 6))
      else $error("supply dropped too soon after data");
   chk_pdown_start: assert property (power_down[0] && port_active[0] |=>
      !card_rst_out[0] ##1 card_ven_out[0] [*8]) else $error("power-down order wrong");
   chk_answer_window: assert property ($rose(port_active[0]) |->
      n_r >= 399 && n_r <= ATR_MAX_CYC) else $error("answer taken outside window");
   chk_rst_low_span: assert property ($rose(card_rst_out[0]) |-> n_r >= RST_LOW_CYC - 1)
      else $error("reset released early");
   chk_fail_deact: assert property ($rose(port_fail[0]) |-> !port_active[0] ##1 !card_rst_out[0])
      else $error("failure did not deactivate");
endmodule

bind scas_top scas_top_chk #(.RST_LOW_CYC(RST_LOW_CYC), .ATR_MAX_CYC(ATR_MAX_CYC)) u_chk (
   .clk_sys(clk_sys), .rst(rst), .power_down(power_down), .port_active(port_active),
   .port_fail(port_fail), .port_busy(port_busy), .card_clock_out(card_clock_out),
   .card_rst_out(card_rst_out), .card_tx_out(card_tx_out), .card_ven_out(card_ven_out));

`default_nettype wire

// ===== sim/sim_card_activation_sequencer_tb.sv
// Testbench for the sequencer: activation rows, then reset and refusal.
// Assumes card models on both ports; port 1 in five-pin form, half period under the clamp.
`timescale 1ns/100ps
`default_nettype none

module sim_card_activation_sequencer_tb;
   typedef struct {int p; logic low, r16; int at; logic wr, rm, ok;} scas_row_t;
   logic       clk_sys = 1'b0;
   logic       rst = 1'b1;
   logic       slow_clk = 1'b0;
   logic [1:0] act_start = 2'h0, low_card = 2'h0, power_down = 2'h0, ratio = 2'h0;
   logic [1:0] tx_bit = 2'h3, present = 2'h3, wrst = 2'h0;
   logic [1:0] act, fl, bsy, tick, rx_bit, cclk, crst, ctx, cven, oe, rx_w, dq;
   int         ans [2] = '{0, 0};
   int         n_fail = 0;
   int         checks_done = 0;
   scas_row_t  rows [7] = '{'{0, 0, 0, 420, 0, 0, 1}, '{0, 0, 1, 590, 0, 0, 1},
      '{0, 0, 0, 350, 0, 0, 0}, '{0, 0, 0, 0, 0, 0, 0}, '{0, 1, 1, 450, 1, 0, 1},
      '{0, 1, 0, 300, 0, 0, 0}, '{1, 0, 1, 450, 0, 1, 1}};

   // Clocks: system 10 ns, slow reference 80 ns at an odd phase
   always #5 clk_sys = ~clk_sys;
   initial begin
      #3.7;
      forever #40 slow_clk = ~slow_clk;
   end

   scas_top #(.RST_LOW_CYC(600), .ATR_MAX_CYC(600)) dut (
      .clk_sys(clk_sys), .rst(rst), .slow_reference_clock(slow_clk), .act_start(act_start),
      .act_low_reset_card(low_card), .power_down(power_down), .ratio_16(ratio),
      .five_pin_mode(2'h2), .clk_half_period({13'h004, 13'h00A}), .tx_bit(tx_bit),
      .port_active(act), .port_fail(fl), .port_busy(bsy), .etu_tick(tick), .rx_bit(rx_bit),
      .card_presence_detect(present), .card_rx_in(rx_w), .card_clock_out(cclk),
      .card_rst_out(crst), .card_tx_out(ctx), .card_ven_out(cven),
      .bidirectional_card_data_in(rx_w & ~oe), .bidirectional_card_data_out(dq),
      .bidirectional_card_data_oe(oe));

   for (genvar g = 0; g < 2; g++) begin : g_card
      scas_card_model card (.cclk(cclk[g]), .ven(cven[g]), .rst_pin(crst[g]), .rx(rx_w[g]),
         .ans_at(ans[g]), .wait_rst(wrst[g]));
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic finish_test;
      $display("Checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Rises and high time over one bit period
   task automatic etu(input int p, input int r);
      int n, hi;
      logic c;
      n = 0;
      hi = 0;
      while (!tick[p]) @(negedge clk_sys);
      c = cclk[p];
      do begin
         @(negedge clk_sys);
         n += (cclk[p] && !c);
         c = cclk[p];
         hi += c;
      end while (!tick[p]);
      chk("rises per bit", r, n);
      chk("duty", 1, hi >= r * 10 - 2 && hi <= r * 10 + 2);
   endtask

   // Last cycle each pin was high during deactivation
   task automatic deact(input int p);
      int t, lr, lc, lt, lv;
      lr = -1;
      lc = -1;
      lt = -1;
      lv = -1;
      for (t = 0; t < 4000 && (bsy[p] || act[p]); t++) begin
         @(negedge clk_sys);
         if (crst[p]) lr = t;
         if (cclk[p]) lc = t;
         if (ctx[p]) lt = t;
         if (cven[p]) lv = t;
      end
      chk("order", 1, lr < lc && lc < lt && lt < lv);
      chk("spacing", 1, lt - lc >= 7 && lv - lt >= 7);
      chk("idle pins", 0, {crst[p], cclk[p], ctx[p], cven[p]});
   endtask

   task automatic run_row(input scas_row_t r);
      int t;
      @(negedge clk_sys);
      low_card[r.p] = r.low;
      ratio[r.p] = r.r16;
      ans[r.p] = r.at;
      wrst[r.p] = r.wr;
      act_start[r.p] = 1'b1;
      @(negedge clk_sys) act_start[r.p] = 1'b0;
      for (t = 0; t < 30000 && !act[r.p] && !fl[r.p]; t++) @(negedge clk_sys);
      chk("active", r.ok, act[r.p]);
      chk("fail", !r.ok, fl[r.p]);
      if (r.ok) begin
         chk("reset pin", r.low, crst[r.p]);
         chk("rx bit", 0, rx_bit[r.p]);
         etu(r.p, r.r16 ? 16 : 372);
         tx_bit[r.p] = 1'b0;
         repeat (4) @(negedge clk_sys);
         chk("data pull", r.p == 1, oe[r.p]);
         chk("tx pin", 0, ctx[r.p]);
         chk("data out", 0, dq[r.p]);
         tx_bit[r.p] = 1'b1;
         if (r.rm) present[r.p] = 1'b0;
         else power_down[r.p] = 1'b1;
         @(negedge clk_sys) power_down[r.p] = 1'b0;
      end
      deact(r.p);
      present[r.p] = 1'b1;
      repeat (5) @(negedge clk_sys);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog on the whole run
   initial begin
      #1300000;
      n_fail++;
      finish_test;
   end

   // Main sequence
   initial begin
      repeat (6) @(negedge clk_sys);
      rst = 1'b0;
      repeat (3) @(negedge clk_sys);
      foreach (rows[i]) begin
         run_row(rows[i]);
         $display("Row %0d done", i);
      end
      ans[0] = 420;
      low_card[0] = 1'b0;
      act_start[0] = 1'b1;
      @(negedge clk_sys) act_start[0] = 1'b0;
      repeat (300) @(negedge clk_sys);
      rst = 1'b1;
      repeat (6) @(negedge clk_sys);
      chk("pins in reset", 0, {crst, cclk, ctx, cven, oe});
      chk("rx in reset", 2'h3, rx_bit);
      rst = 1'b0;
      $display("Reset test done");
      present[0] = 1'b0;
      repeat (4) @(negedge clk_sys);
      act_start[0] = 1'b1;
      @(negedge clk_sys) act_start[0] = 1'b0;
      repeat (5) @(negedge clk_sys);
      chk("start without card", 0, {bsy[0], cven[0]});
      $display("Refusal test done");
      finish_test;
   end
endmodule

`default_nettype wire
